/* core/obd_decoder.sv */
// Instruction byte sequencer and decode result builder
// What this block does
// RULE1 - Form 11 makes base field a register
// RULE2 - Form 00: zero displacement, no bytes
// RULE3 - Form 01: one byte, sign-extended
// RULE4 - Form 10: two bytes, high:low
// RULE5 - Base 000-011: paired register sums
// RULE6 - Base 100-111: single register plus displacement
// RULE7 - Form 00 base 110: direct address
// RULE8 - Displacement bytes precede immediate bytes
// RULE9 - s:w 01 word immediate, 11 sign-extended
// RULE10 - Shift count one or low counter byte
// RULE11 - Direction and width bits steer operands
// RULE12 - Register code maps word or byte half
// RULE13 - Repeat compare bit tested against zero
// RULE14 - Status word bit packing
// RULE15 - Above/below unsigned, greater/less signed
// RULE16 - Loop-until-equal decrements, tests counter and zero
// RULE17 - Counter-zero branch leaves counter unchanged
// RULE18 - Overflow trap only with overflow set
// RULE19 - Near/far return with optional stack adjust
// RULE20 - Escape decodes operand, hands to coprocessor
// RULE21 - Lock prefix holds bus for next instruction
// RULE22 - Store string writes low byte or word
// RULE23 - One decode result per instruction
`timescale 1ns/1ps
module obd_decoder
  import obd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_data,
  output logic             byte_ready,
  input  wire obd_regs_t   regs,
  input  wire logic [15:0] status_word,
  input  wire logic        res_ready,
  output logic             res_valid,
  output obd_result_t      res,
  output logic             bus_lock
);
  // ********************************
  // Opcode classing
  // ********************************
  function automatic obd_cls_t op_class(input logic [7:0] op);
    obd_cls_t c;
    c = '{1'b0, 3'h0, 1'b0};
    if (op[7:6] == 2'h0 && op[2] == 1'b0) begin
      c.modrm = 1'b1;
    end else if (op[7:6] == 2'h0 && op[2:1] == 2'h2) begin
      c.imm_len = op[W_BIT] ? 3'h2 : 3'h1;
    end else if ((op & GRP4_MASK) == IMMGRP_MATCH) begin
      c.modrm    = 1'b1;
      c.imm_len  = (op[1:0] == 2'h1) ? 3'h2 : 3'h1; // RULE9
      c.imm_sext = op[S_BIT] & op[W_BIT]; // RULE9
    end else if ((op & GRP4_MASK) == SHIFT_MATCH || (op & ESC_MASK) == ESC_MATCH
                 || op == OPC_GRP_FF) begin
      c.modrm = 1'b1; // RULE20
    end else if ((op & JCC_MASK) == JCC_MATCH || (op & GRP4_MASK) == OPC_LOOP_NEQ
                 || op == OPC_JMP_SHORT) begin
      c.imm_len  = 3'h1;
      c.imm_sext = 1'b1; // RULE17
    end else if (op == OPC_CALL_NEAR || op == OPC_JMP_NEAR
                 || ((op & RET_MASK) == RET_MATCH && !op[W_BIT])) begin
      // Plain returns carry no stack adjust bytes
      c.imm_len = 3'h2; // RULE19
    end else if (op == OPC_CALL_FAR || op == OPC_JMP_FAR) begin
      c.imm_len = 3'h4;
    end else if (op == OPC_INT) begin
      c.imm_len = 3'h1;
    end
    return c;
  endfunction : op_class

  function automatic logic [2:0] disp_len(input logic [7:0] m);
    unique case (m[FORM_HI:FORM_LO])
      FORM_NO_DISP: return (m[BASE_HI:BASE_LO] == BASE_DIRECT) ? 3'h2 : 3'h0; // RULE2
      FORM_DISP8:   return 3'h1; // RULE3
      FORM_DISP16:  return 3'h2; // RULE4
      FORM_REG:     return 3'h0; // RULE1
    endcase
  endfunction : disp_len

  // ********************************
  // Sequencer state
  // ********************************
  obd_state_t  st_r, st_nxt;
  obd_cls_t    cls_r, cls_nxt, cls_new;
  logic [7:0]  op_r, op_nxt;
  logic [7:0]  modrm_r, modrm_nxt;
  logic [15:0] disp_r, disp_nxt;
  logic [31:0] imm_r, imm_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [1:0]  idx_r, idx_nxt;
  logic [3:0]  len_r, len_nxt;
  logic        lock_r, lock_nxt;
  logic        rep_r, rep_nxt;
  logic        repz_r, repz_nxt;
  logic        segv_r, segv_nxt;
  logic [1:0]  seg_r, seg_nxt;
  logic        fire;
  logic        slot_free;
  logic        finish;
  logic [2:0]  dn;

  assign byte_ready = (st_r != ST_DONE);
  assign fire       = byte_valid && byte_ready;
  assign slot_free  = !res_valid || res_ready;
  assign finish     = (st_r == ST_DONE) && slot_free;

  always_comb begin
    st_nxt    = st_r;
    cls_nxt   = cls_r;
    op_nxt    = op_r;
    modrm_nxt = modrm_r;
    disp_nxt  = disp_r;
    imm_nxt   = imm_r;
    cnt_nxt   = cnt_r;
    idx_nxt   = idx_r;
    len_nxt   = len_r;
    lock_nxt  = lock_r;
    rep_nxt   = rep_r;
    repz_nxt  = repz_r;
    segv_nxt  = segv_r;
    seg_nxt   = seg_r;
    cls_new   = op_class(byte_data);
    dn        = disp_len(byte_data);
    if (fire) begin
      len_nxt = len_r + 4'h1;
    end
    unique case (st_r)
      ST_OPC: if (fire) begin
        if (byte_data == OPC_LOCK) begin
          lock_nxt = 1'b1; // RULE21
        end else if ((byte_data & REP_MASK) == REP_MATCH) begin
          rep_nxt  = 1'b1;
          repz_nxt = byte_data[0]; // RULE13
        end else if ((byte_data & SEG_MASK) == SEG_MATCH) begin
          segv_nxt = 1'b1;
          seg_nxt  = byte_data[SEG_HI:SEG_LO];
        end else begin
          op_nxt    = byte_data;
          cls_nxt   = cls_new;
          modrm_nxt = 8'h00;
          disp_nxt  = 16'h0000;
          imm_nxt   = 32'h0000_0000;
          idx_nxt   = 2'h0;
          cnt_nxt   = cls_new.imm_len;
          if (cls_new.modrm) begin
            st_nxt = ST_MODRM;
          end else if (cls_new.imm_len != 3'h0) begin
            st_nxt = ST_IMM;
          end else begin
            st_nxt = ST_DONE;
          end
        end
      end
      ST_MODRM: if (fire) begin
        modrm_nxt = byte_data;
        if (dn != 3'h0) begin
          cnt_nxt = dn;
          st_nxt  = ST_DISP; // RULE8
        end else if (cls_r.imm_len != 3'h0) begin
          st_nxt = ST_IMM;
        end else begin
          st_nxt = ST_DONE;
        end
      end
      ST_DISP: if (fire) begin
        // Low byte arrives first
        if (idx_r == 2'h0) begin
          disp_nxt[7:0] = byte_data; // RULE4
        end else begin
          disp_nxt[15:8] = byte_data; // RULE4
        end
        idx_nxt = idx_r + 2'h1;
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h1) begin
          idx_nxt = 2'h0;
          cnt_nxt = cls_r.imm_len;
          st_nxt  = (cls_r.imm_len != 3'h0) ? ST_IMM : ST_DONE; // RULE8
        end
      end
      ST_IMM: if (fire) begin
        imm_nxt = imm_r | ({24'h00_0000, byte_data} << {idx_r, 3'h0}); // RULE19
        idx_nxt = idx_r + 2'h1;
        cnt_nxt = cnt_r - 3'h1;
        if (cnt_r == 3'h1) begin
          st_nxt = ST_DONE;
        end
      end
      ST_DONE: if (slot_free) begin
        st_nxt   = ST_OPC;
        len_nxt  = 4'h0;
        lock_nxt = 1'b0;
        rep_nxt  = 1'b0;
        repz_nxt = 1'b0;
        segv_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r    <= ST_OPC;
      cls_r   <= '{1'b0, 3'h0, 1'b0};
      op_r    <= 8'h00;
      modrm_r <= 8'h00;
      disp_r  <= 16'h0000;
      imm_r   <= 32'h0000_0000;
      cnt_r   <= 3'h0;
      idx_r   <= 2'h0;
      len_r   <= 4'h0;
      lock_r  <= 1'b0;
      rep_r   <= 1'b0;
      repz_r  <= 1'b0;
      segv_r  <= 1'b0;
      seg_r   <= 2'h0;
    end else begin
      st_r    <= st_nxt;
      cls_r   <= cls_nxt;
      op_r    <= op_nxt;
      modrm_r <= modrm_nxt;
      disp_r  <= disp_nxt;
      imm_r   <= imm_nxt;
      cnt_r   <= cnt_nxt;
      idx_r   <= idx_nxt;
      len_r   <= len_nxt;
      lock_r  <= lock_nxt;
      rep_r   <= rep_nxt;
      repz_r  <= repz_nxt;
      segv_r  <= segv_nxt;
      seg_r   <= seg_nxt;
    end
  end

  // ********************************
  // Operand and branch evaluation
  // ********************************
  obd_flags_t  flags;
  logic [15:0] ea_disp;
  logic [15:0] ea_addr;
  logic        ea_direct;
  logic        br_taken;
  logic [15:0] br_counter;
  logic        br_trap;

  assign flags = flags_unpack(status_word); // RULE14

  obd_ea u_ea (
    .form           (modrm_r[FORM_HI:FORM_LO]),
    .base           (modrm_r[BASE_HI:BASE_LO]),
    .disp_lo        (disp_r[7:0]),
    .disp_hi        (disp_r[15:8]),
    .regs           (regs),
    .disp           (ea_disp),
    .effective_addr (ea_addr),
    .direct         (ea_direct)
  );

  obd_branch u_branch (
    .opcode       (op_r),
    .flags        (flags),
    .loop_counter (regs.loop_counter),
    .taken        (br_taken),
    .counter_new  (br_counter),
    .ovf_trap     (br_trap)
  );

  // ********************************
  // Decode result
  // ********************************
  obd_result_t res_r, res_nxt;
  logic        res_valid_r, res_valid_nxt;
  logic        bus_lock_r, bus_lock_nxt;
  obd_sel_t    reg_sel;
  obd_sel_t    rm_sel;
  logic        w;
  logic        d;

  assign res_valid = res_valid_r;
  assign res       = res_r;
  assign bus_lock  = bus_lock_r;

  always_comb begin
    res_nxt       = res_r;
    res_valid_nxt = res_valid_r && !res_ready;
    w             = op_r[W_BIT];
    d             = op_r[D_BIT];
    reg_sel       = sel_decode(modrm_r[REG_HI:REG_LO], w); // RULE12
    rm_sel        = sel_decode(modrm_r[BASE_HI:BASE_LO], w); // RULE1
    if (finish) begin
      res_valid_nxt          = 1'b1; // RULE23
      res_nxt.opcode         = op_r;
      res_nxt.has_modrm      = cls_r.modrm;
      res_nxt.form           = modrm_r[FORM_HI:FORM_LO];
      res_nxt.reg_f          = modrm_r[REG_HI:REG_LO];
      res_nxt.base_f         = modrm_r[BASE_HI:BASE_LO];
      res_nxt.word_op        = w; // RULE11
      res_nxt.dir_to_reg     = d; // RULE11
      res_nxt.dst_sel        = d ? reg_sel : rm_sel; // RULE11
      res_nxt.src_sel        = d ? rm_sel : reg_sel; // RULE11
      res_nxt.rm_is_reg      = cls_r.modrm && modrm_r[FORM_HI:FORM_LO] == FORM_REG; // RULE1
      res_nxt.disp           = cls_r.modrm ? ea_disp : 16'h0000;
      res_nxt.effective_addr = ea_addr; // RULE20
      res_nxt.direct_addr    = cls_r.modrm && ea_direct;
      res_nxt.imm            = cls_r.imm_sext ? sext8(imm_r[7:0]) : imm_r[15:0]; // RULE9
      res_nxt.seg_imm        = imm_r[31:16];
      res_nxt.length         = len_r;
      res_nxt.shift_count    = 8'h00;
      if ((op_r & GRP4_MASK) == SHIFT_MATCH) begin
        res_nxt.shift_count = op_r[V_BIT] ? regs.loop_counter[7:0] : 8'h01; // RULE10
      end
      res_nxt.branch_taken     = br_taken; // RULE15
      res_nxt.loop_counter_new = br_counter; // RULE16
      res_nxt.int_req          = op_r == OPC_INT || op_r == OPC_INT3 || br_trap; // RULE18
      res_nxt.int_type         = (op_r == OPC_INT) ? imm_r[7:0]
                               : (op_r == OPC_INT3) ? INT3_TYPE : OVF_TYPE;
      res_nxt.is_ret           = (op_r & RET_MASK) == RET_MATCH; // RULE19
      res_nxt.ret_far          = op_r[3]; // RULE19
      // Stack adjust applies after the return address has been popped
      res_nxt.stack_top_new    = regs.stack_top + (op_r[3] ? FAR_POP : NEAR_POP)
                               + (op_r[0] ? 16'h0000 : imm_r[15:0]); // RULE19
      res_nxt.coproc_escape    = (op_r & ESC_MASK) == ESC_MATCH; // RULE20
      res_nxt.lock             = lock_r; // RULE21
      res_nxt.rep              = rep_r;
      res_nxt.rep_z            = repz_r;
      res_nxt.rep_continue     = rep_r && (flags.zero_flag == repz_r); // RULE13
      res_nxt.seg_valid        = segv_r;
      res_nxt.seg              = seg_r;
      res_nxt.store_string     = (op_r & STR_MASK) == STORE_MATCH; // RULE22
      res_nxt.store_data       = w ? regs.acc_word : {8'h00, regs.acc_word[7:0]}; // RULE22
    end
    // Lock spans prefix through acceptance of the locked instruction
    bus_lock_nxt = lock_nxt || (res_valid_nxt && res_nxt.lock); // RULE21
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res_r       <= '0;
      res_valid_r <= 1'b0;
      bus_lock_r  <= 1'b0;
    end else begin
      res_r       <= res_nxt;
      res_valid_r <= res_valid_nxt;
      bus_lock_r  <= bus_lock_nxt;
    end
  end
endmodule : obd_decoder

/* core/obd_pkg.sv */
// Shared constants, types and helper functions of the operand and branch decoder
package obd_pkg;
  // ********************************
  // Operand byte and opcode fields
  // ********************************
  localparam int FORM_HI = 7;
  localparam int FORM_LO = 6;
  localparam int REG_HI  = 5;
  localparam int REG_LO  = 3;
  localparam int BASE_HI = 2;
  localparam int BASE_LO = 0;
  localparam int W_BIT   = 0;
  localparam int D_BIT   = 1;
  localparam int V_BIT   = 1;
  localparam int S_BIT   = 1;
  localparam int SEG_HI  = 4;
  localparam int SEG_LO  = 3;
  localparam logic [1:0] FORM_NO_DISP = 2'h0;
  localparam logic [1:0] FORM_DISP8   = 2'h1;
  localparam logic [1:0] FORM_DISP16  = 2'h2;
  localparam logic [1:0] FORM_REG     = 2'h3;
  localparam logic [2:0] BASE_DIRECT  = 3'h6;
  localparam logic [2:0] HALF_SPLIT   = 3'h4;
  // ********************************
  // Opcodes
  // ********************************
  localparam logic [7:0] OPC_LOCK      = 8'hF0;
  localparam logic [7:0] REP_MASK      = 8'hFE;
  localparam logic [7:0] REP_MATCH     = 8'hF2;
  localparam logic [7:0] SEG_MASK      = 8'hE7;
  localparam logic [7:0] SEG_MATCH     = 8'h26;
  localparam logic [7:0] ESC_MASK      = 8'hF8;
  localparam logic [7:0] ESC_MATCH     = 8'hD8;
  localparam logic [7:0] GRP4_MASK     = 8'hFC;
  localparam logic [7:0] SHIFT_MATCH   = 8'hD0;
  localparam logic [7:0] IMMGRP_MATCH  = 8'h80;
  localparam logic [7:0] STR_MASK      = 8'hFE;
  localparam logic [7:0] STORE_MATCH   = 8'hAA;
  localparam logic [7:0] JCC_MASK      = 8'hF0;
  localparam logic [7:0] JCC_MATCH     = 8'h70;
  localparam logic [7:0] RET_MASK      = 8'hF6;
  localparam logic [7:0] RET_MATCH     = 8'hC2;
  localparam logic [7:0] OPC_LOOP_NEQ  = 8'hE0;
  localparam logic [7:0] OPC_LOOPZ     = 8'hE1;
  localparam logic [7:0] OPC_LOOP      = 8'hE2;
  localparam logic [7:0] OPC_CXZ       = 8'hE3;
  localparam logic [7:0] OPC_INT3      = 8'hCC;
  localparam logic [7:0] OPC_INT       = 8'hCD;
  localparam logic [7:0] OPC_OVERFLOW_TRAP      = 8'hCE;
  localparam logic [7:0] OPC_CALL_NEAR = 8'hE8;
  localparam logic [7:0] OPC_JMP_NEAR  = 8'hE9;
  localparam logic [7:0] OPC_JMP_SHORT = 8'hEB;
  localparam logic [7:0] OPC_CALL_FAR  = 8'h9A;
  localparam logic [7:0] OPC_JMP_FAR   = 8'hEA;
  localparam logic [7:0] OPC_GRP_FF    = 8'hFF;
  localparam logic [7:0] INT3_TYPE     = 8'h03;
  localparam logic [7:0] OVF_TYPE      = 8'h04;
  localparam logic [15:0] NEAR_POP     = 16'h0002;
  localparam logic [15:0] FAR_POP      = 16'h0004;
  // ********************************
  // Status word bit positions
  // ********************************
  localparam int OVF_BIT = 11;
  localparam int DIR_BIT = 10;
  localparam int IEN_BIT = 9;
  localparam int TRP_BIT = 8;
  localparam int SGN_BIT = 7;
  localparam int ZER_BIT = 6;
  localparam int AUX_BIT = 4;
  localparam int PAR_BIT = 2;
  localparam int CRY_BIT = 0;
  // ********************************
  // Types
  // ********************************
  typedef enum logic [2:0] {ST_OPC, ST_MODRM, ST_DISP, ST_IMM, ST_DONE} obd_state_t;
  typedef struct packed { logic [2:0] idx; logic hi_half; } obd_sel_t;
  typedef struct packed {
    logic overflow_flag, direction_flag, int_enable_flag, trap_flag;
    logic sign_flag, zero_flag, aux_carry_flag, parity_flag, carry_flag;
  } obd_flags_t;
  typedef struct packed {
    logic [15:0] acc_word, loop_counter, base_reg, frame_base;
    logic [15:0] src_index, dest_index, stack_top;
  } obd_regs_t;
  typedef struct packed { logic modrm; logic [2:0] imm_len; logic imm_sext; } obd_cls_t;
  typedef struct packed {
    logic [7:0]  opcode;
    logic        has_modrm;
    logic [1:0]  form;
    logic [2:0]  reg_f;
    logic [2:0]  base_f;
    logic        word_op;
    logic        dir_to_reg;
    obd_sel_t    dst_sel;
    obd_sel_t    src_sel;
    logic        rm_is_reg;
    logic [15:0] disp;
    logic [15:0] effective_addr;
    logic        direct_addr;
    logic [15:0] imm;
    logic [15:0] seg_imm;
    logic [3:0]  length;
    logic [7:0]  shift_count;
    logic        branch_taken;
    logic [15:0] loop_counter_new;
    logic        int_req;
    logic [7:0]  int_type;
    logic        is_ret;
    logic        ret_far;
    logic [15:0] stack_top_new;
    logic        coproc_escape;
    logic        lock;
    logic        rep;
    logic        rep_z;
    logic        rep_continue;
    logic        seg_valid;
    logic [1:0]  seg;
    logic        store_string;
    logic [15:0] store_data;
  } obd_result_t;
  // ********************************
  // Functions
  // ********************************
  function automatic logic [15:0] sext8(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction : sext8
  function automatic obd_flags_t flags_unpack(input logic [15:0] w);
    return '{w[OVF_BIT], w[DIR_BIT], w[IEN_BIT], w[TRP_BIT], w[SGN_BIT],
             w[ZER_BIT], w[AUX_BIT], w[PAR_BIT], w[CRY_BIT]};
  endfunction : flags_unpack
  function automatic obd_sel_t sel_decode(input logic [2:0] code, input logic word);
    obd_sel_t s;
    s.idx     = code;
    s.hi_half = 1'b0;
    if (!word && code >= HALF_SPLIT) begin
      s.idx     = code - HALF_SPLIT;
      s.hi_half = 1'b1;
    end
    return s;
  endfunction : sel_decode
endpackage : obd_pkg

/* core/obd_ea.sv */
// Displacement and effective address former
`timescale 1ns/1ps
module obd_ea
  import obd_pkg::*;
(
  input  wire logic [1:0]  form,
  input  wire logic [2:0]  base,
  input  wire logic [7:0]  disp_lo,
  input  wire logic [7:0]  disp_hi,
  input  wire obd_regs_t   regs,
  output logic      [15:0] disp,
  output logic      [15:0] effective_addr,
  output logic             direct
);
  logic [15:0] sum;

  always_comb begin
    direct = (form == FORM_NO_DISP) && (base == BASE_DIRECT); // RULE7
    unique case (form)
      FORM_NO_DISP: disp = direct ? {disp_hi, disp_lo} : 16'h0000; // RULE2
      FORM_DISP8:   disp = sext8(disp_lo); // RULE3
      FORM_DISP16:  disp = {disp_hi, disp_lo}; // RULE4
      FORM_REG:     disp = 16'h0000;
    endcase
    unique case (base)
      3'h0: sum = regs.base_reg + regs.src_index; // RULE5
      3'h1: sum = regs.base_reg + regs.dest_index; // RULE5
      3'h2: sum = regs.frame_base + regs.src_index; // RULE5
      3'h3: sum = regs.frame_base + regs.dest_index; // RULE5
      3'h4: sum = regs.src_index; // RULE6
      3'h5: sum = regs.dest_index; // RULE6
      3'h6: sum = regs.frame_base; // RULE6
      3'h7: sum = regs.base_reg; // RULE6
    endcase
    // Address wraps within the 16-bit offset space
    effective_addr = direct ? disp : sum + disp; // RULE7
  end
endmodule : obd_ea

/* core/obd_branch.sv */
// Branch, loop and overflow trap condition evaluator
`timescale 1ns/1ps
module obd_branch
  import obd_pkg::*;
(
  input  wire logic [7:0]  opcode,
  input  wire obd_flags_t  flags,
  input  wire logic [15:0] loop_counter,
  output logic             taken,
  output logic      [15:0] counter_new,
  output logic             ovf_trap
);
  logic [15:0] dec;
  logic        cond;

  always_comb begin
    dec         = loop_counter - 16'h0001;
    counter_new = loop_counter;
    unique case (opcode[3:1])
      3'h0: cond = flags.overflow_flag;
      3'h1: cond = flags.carry_flag; // RULE15
      3'h2: cond = flags.zero_flag;
      3'h3: cond = flags.carry_flag | flags.zero_flag; // RULE15
      3'h4: cond = flags.sign_flag;
      3'h5: cond = flags.parity_flag;
      3'h6: cond = flags.sign_flag ^ flags.overflow_flag; // RULE15
      3'h7: cond = (flags.sign_flag ^ flags.overflow_flag) | flags.zero_flag; // RULE15
    endcase
    taken = 1'b0;
    if ((opcode & JCC_MASK) == JCC_MATCH) begin
      taken = cond ^ opcode[0];
    end else begin
      unique case (opcode)
        OPC_LOOP_NEQ: begin
          counter_new = dec; // RULE16
          taken       = (dec != 16'h0000) && !flags.zero_flag; // RULE16
        end
        OPC_LOOPZ: begin
          counter_new = dec;
          taken       = (dec != 16'h0000) && flags.zero_flag;
        end
        OPC_LOOP: begin
          counter_new = dec;
          taken       = dec != 16'h0000;
        end
        OPC_CXZ: taken = loop_counter == 16'h0000; // RULE17
        OPC_CALL_NEAR, OPC_JMP_NEAR, OPC_JMP_SHORT, OPC_CALL_FAR, OPC_JMP_FAR: taken = 1'b1;
        default: taken = 1'b0;
      endcase
    end
    ovf_trap = (opcode == OPC_OVERFLOW_TRAP) && flags.overflow_flag; // RULE18
  end
endmodule : obd_branch

/* test/obd_decoder_sva.sv */
// Port-level assertions for the operand and branch decoder
`timescale 1ns/1ps
module obd_decoder_sva
  import obd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        byte_valid,
  input wire logic [7:0]  byte_data,
  input wire logic        byte_ready,
  input wire logic        res_ready,
  input wire logic        res_valid,
  input wire obd_result_t res,
  input wire logic        bus_lock
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic m;
  assign m = res_valid && res.has_modrm;
  property p_rm; m |-> res.rm_is_reg == (res.form == FORM_REG); endproperty
  a_rm: assert property (p_rm) else $error("rm kind");
  property p_d0;
    m && res.form == FORM_NO_DISP && res.base_f != BASE_DIRECT |-> res.disp == 16'h0000;
  endproperty
  a_d0: assert property (p_d0) else $error("disp not zero");
  property p_d8; m && res.form == FORM_DISP8 |-> res.disp == {{8{res.disp[7]}}, res.disp[7:0]};
  endproperty
  a_d8: assert property (p_d8) else $error("disp8 ext");
  property p_dir; m && res.form == FORM_NO_DISP && res.base_f == BASE_DIRECT
    |-> res.direct_addr && res.effective_addr == res.disp; endproperty
  a_dir: assert property (p_dir) else $error("direct addr");
  property p_sx; res_valid && res.opcode == 8'h83 |-> res.imm == {{8{res.imm[7]}}, res.imm[7:0]};
  endproperty
  a_sx: assert property (p_sx) else $error("imm ext");
  property p_dw; m && res.opcode[7:6] == 2'h0
    |-> res.word_op == res.opcode[0] && res.dir_to_reg == res.opcode[1]; endproperty
  a_dw: assert property (p_dw) else $error("d or w bit");
  property p_lk; $rose(bus_lock) |-> $past(byte_valid && byte_ready && byte_data == OPC_LOCK);
  endproperty
  a_lk: assert property (p_lk) else $error("lock start");
  property p_hold; res_valid && !res_ready |=> res_valid && $stable(res); endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  c_dir: cover property (res_valid && res.direct_addr);
  c_jmp: cover property (res_valid && res_ready && res.branch_taken);
  c_lk: cover property ($rose(bus_lock));
endmodule : obd_decoder_sva
bind obd_decoder obd_decoder_sva obd_decoder_sva_inst (.*);

/* test/obd_feeder.sv */
// Prefetch queue and result taker model facing the decoder
`timescale 1ns/1ps
module obd_feeder (
  input  wire logic       clk,
  input  wire logic       byte_ready,
  output logic            byte_valid,
  output logic [7:0]      byte_data,
  input  wire logic       res_valid,
  output logic            res_ready
);
  logic [7:0] q[$];
  logic       hold;
  initial {byte_valid, byte_data, res_ready} = '0;
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask : push
  // Idle data line toggles so a stale byte never passes for a fresh one
  always @(posedge clk) begin
    hold = byte_valid && !byte_ready;
    if (byte_valid && byte_ready) void'(q.pop_front());
    #1;
    res_ready = $urandom_range(2) != 0;
    if (!hold) begin
      byte_valid = q.size() > 0 && $urandom_range(3) != 0;
      byte_data = byte_valid ? q[0] : ~byte_data;
    end
  end
endmodule : obd_feeder

/* test/tb_obd_decoder.sv */
// Self-checking bench for the operand and branch decoder
`timescale 1ns/1ps
module tb_obd_decoder;
  import obd_pkg::*;
  localparam logic [7:0]  ROP [4] = '{8'h81, 8'h83, 8'h03, 8'h02};
  // Entry: taken, opcode, status word
  localparam logic [31:0] BR [6] = '{32'h01720001, 32'h00720080, 32'h01770000,
                                     32'h00770040, 32'h017C0080, 32'h017F0880};
  logic        clk, rst_b, byte_valid, byte_ready, res_ready, res_valid, bus_lock, dr;
  logic [7:0]  byte_data, op, md, q[$];
  logic [15:0] status_word, d, im, ed, eb[8];
  int          nd, ni, miscompares, n_checks;
  obd_regs_t   regs;
  obd_result_t res, r;
  obd_decoder obd_decoder_inst (.*);
  obd_feeder obd_feeder_inst (.*);
  initial forever #2 clk = ~clk;
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic send(input logic [7:0] b[$], input logic [15:0] st);
    #1;
    status_word = st;
    foreach (b[i]) obd_feeder_inst.push(b[i]);
    for (int i = 0; i < 100; i++) begin
      @(posedge clk);
      if (res_valid && res_ready) begin
        r = res;
        return;
      end
    end
    chk("done", 16'h0000, 16'h0001);
  endtask : send
  initial begin
    {clk, rst_b, status_word, regs} = '0;
    void'($urandom(10));
    repeat (12) @(posedge clk);
    #1;
    rst_b = 1'b1;
    regs = obd_regs_t'({$urandom, $urandom, $urandom, $urandom});
    regs.loop_counter = 16'h0002;
    eb = '{regs.base_reg + regs.src_index, regs.base_reg + regs.dest_index,
           regs.frame_base + regs.src_index, regs.frame_base + regs.dest_index,
           regs.src_index, regs.dest_index, regs.frame_base, regs.base_reg};
    for (int n = 0; n < 30; n++) begin
      op = ROP[n % 4];
      {md, d, im} = 40'({$urandom, $urandom});
      dr = md[7:6] == 2'h0 && md[2:0] == 3'h6;
      nd = (dr || md[7:6] == 2'h2) ? 2 : int'(md[7:6] == 2'h1);
      ni = op == 8'h81 ? 2 : int'(op == 8'h83);
      q = '{op, md, d[7:0], d[15:8], im[7:0], im[15:8]};
      if (ni < 2) q.delete(5);
      if (ni < 1) q.delete(4);
      if (nd < 2) q.delete(3);
      if (nd < 1) q.delete(2);
      ed = nd == 2 ? d : nd == 1 ? {{8{d[7]}}, d[7:0]} : 16'h0000;
      send(q, 16'($urandom));
      chk("disp", r.disp, ed);
      chk("len", 16'(r.length), 16'(2 + nd + ni));
      if (md[7:6] != 2'h3) chk("ea", r.effective_addr, dr ? d : eb[md[2:0]] + ed);
      if (ni > 0) chk("imm", r.imm, ni == 2 ? im : {{8{im[7]}}, im[7:0]});
      if (ni == 0) chk("dst", 16'(r.dst_sel),
                       16'(op[0] ? {md[5:3], 1'b0} : {1'b0, md[4:3], md[5]}));
    end
    foreach (BR[i]) begin
      send('{BR[i][23:16], 8'h05}, BR[i][15:0]);
      chk("jcc", 16'(r.branch_taken), 16'(BR[i][24]));
    end
    send('{8'hE0, 8'hFE}, 16'h0000);
    chk("loop", {r.branch_taken, r.loop_counter_new[14:0]}, 16'h8001);
    send('{8'hE3, 8'h10}, 16'h0040);
    chk("cxz", {r.branch_taken, r.loop_counter_new[14:0]}, 16'h0002);
    send('{8'hCE}, 16'h0800);
    chk("trap", {7'h00, r.int_req, r.int_type}, 16'h0104);
    send('{8'hCE}, 16'h0000);
    chk("notrap", 16'(r.int_req), 16'h0000);
    send('{8'hCA, 8'h10, 8'h00}, 16'h0000);
    chk("ret", r.stack_top_new, regs.stack_top + 16'h0014);
    send('{8'hC3}, 16'h0000);
    chk("ret1", r.stack_top_new, regs.stack_top + 16'h0002);
    send('{8'hF0, 8'hF3, 8'hA6}, 16'h0040);
    chk("pfx", {r.lock, r.rep_continue, 10'h000, r.length}, 16'hC003);
    send('{8'hD2, 8'hC1}, 16'h0000);
    chk("cnt", 16'(r.shift_count), 16'h0002);
    send('{8'hD0, 8'hC1}, 16'h0000);
    chk("cnt1", 16'(r.shift_count), 16'h0001);
    send('{8'hAA}, 16'h0000);
    chk("store", r.store_data, {8'h00, regs.acc_word[7:0]});
    regs.loop_counter = 16'h0000;
    send('{8'hE3, 8'h10}, 16'h0000);
    chk("cxz0", {r.branch_taken, r.loop_counter_new[14:0]}, 16'h8000);
    tally_and_finish();
  end
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end
endmodule : tb_obd_decoder
